// ### logic/psq_pkg.sv
// Package for the power sequencing and fault record block.
package psq_pkg;
  // Register addresses.
  localparam logic [15:0] ADDR_DELAYS = 16'hfe06;
  localparam logic [15:0] ADDR_FAULT_RECORD = 16'hfe07;
  localparam logic [15:0] ADDR_FLAG_MASK_A = 16'hfe08;
  // Field positions.
  localparam int ON_DELAY_LSB = 2;
  localparam int OFF_DELAY_LSB = 0;
  localparam int CUR_ID_LSB = 0;
  localparam int PREV_ID_LSB = 4;
  // Reset values.
  localparam logic [3:0] DELAYS_RESET = 4'h0;
  localparam logic [7:0] FLAG_MASK_RESET = 8'h00;
  localparam logic [3:0] NO_FAULT = 4'h0;
  // Delay codes in milliseconds, clock rate and delay counter width.
  localparam int DELAY1_MS = 50;
  localparam int DELAY2_MS = 250;
  localparam int DELAY3_MS = 1000;
  localparam int CLK_MHZ = 100;
  localparam int CYCLES_PER_MS = CLK_MHZ * 1000;
  localparam int CNT_W = 27;
  // Flag bit positions in the protection flag vector, same as the mask bits.
  localparam int FLAG_OUT_OV = 0;
  localparam int FLAG_OUT_UV = 1;
  localparam int FLAG_OVER_TEMP = 2;
  localparam int FLAG_IN_OV = 3;
  localparam int FLAG_IN_ABSENT = 4;
  localparam int FLAG_IN_OC = 5;
  localparam int FLAG_OVERLOAD = 6;
  localparam int FLAG_QUICK_OV = 7;
  // Fault identifiers.
  typedef enum logic [3:0] {
    FID_NONE = 4'h0,
    FID_OUTPUT_OV = 4'h1,
    FID_OUTPUT_UV = 4'h2,
    FID_OVER_TEMP = 4'h3,
    FID_INPUT_OV = 4'h4,
    FID_INPUT_UV = 4'h5,
    FID_INPUT_OC = 4'h6,
    FID_OVERLOAD = 4'h7,
    FID_QUICK_OV = 4'h8,
    FID_QUICK_OC = 4'h9,
    FID_LOGIC_SUPPLY_OV = 4'ha,
    FID_CORE_SUPPLY_OV = 4'hb
  } psq_fault_id_t;
  // Sequencer states.
  typedef enum logic [2:0] {
    ST_OFF = 3'b000,
    ST_ON_WAIT = 3'b001,
    ST_SOFT_START = 3'b010,
    ST_RUN = 3'b011,
    ST_OFF_WAIT = 3'b100
  } psq_state_t;
  // Register bus request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } psq_req_t;
endpackage

// ### logic/psq_sequencer.sv
// Power-on sequencer with soft-start flag masking and shutdown fault record.
// How it works
// - Bits 3:2 of the delay register pick 0, 50, 250 or 1000 ms from request rising to soft start.
// - Bits 1:0 pick the same four delays from request falling to converter off.
// - A fault shutdown stores its 4-bit identifier in the read-only low nibble of the record.
// - The identifier of the fault just before it sits in the read-only high nibble.
// - Identifiers run 1 to 11 from output overvoltage to core supply overvoltage.
// - During soft start each set mask bit suppresses its flag; a clear bit leaves it active.
// - Mask bits 7, 6, 5 cover quick overvoltage, overload and input overcurrent.
// - Mask bits 4 and 3 cover input absent and input overvoltage.
// - Mask bits 2, 1, 0 cover overtemperature, output undervoltage and output overvoltage.
// - When enabled, the first fault identifier is sent to nonvolatile memory at shutdown.
`timescale 1ns/10ps
module psq_sequencer
  import psq_pkg::*;
#(
  parameter int MS_CYCLES = CYCLES_PER_MS
)
(
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset_n,
  // Register access.
  input wire psq_req_t reg_req,
  output logic [7:0] reg_rdata,
  // Sequencing.
  input wire logic power_on_request,
  input wire logic soft_start_done,
  output logic soft_start,
  output logic converter_on,
  // Protection flags, bit order as the mask register.
  input wire logic [7:0] protect_flags,
  output logic [7:0] active_flags,
  // Shutdown faults.
  input wire logic fault_shutdown,
  input wire logic [3:0] fault_id,
  input wire logic save_id_enable,
  output logic nvm_save,
  output logic [3:0] nvm_save_id
);

  psq_state_t state;
  psq_state_t next_state;
  logic [3:0] delays;
  logic [7:0] flag_mask;
  logic [3:0] cur_id;
  logic [3:0] prev_id;
  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic req_d;
  logic first_saved;

  function automatic logic [CNT_W-1:0] delay_cycles(input logic [1:0] code);
    int ms;
    ms = 0;
    case (code)
      2'b01: ms = DELAY1_MS;
      2'b10: ms = DELAY2_MS;
      2'b11: ms = DELAY3_MS;
      default: ms = 0;
    endcase
    delay_cycles = CNT_W'(ms * MS_CYCLES);
  endfunction

  wire req_rise = power_on_request && !req_d;
  wire req_fall = !power_on_request && req_d;
  wire wr_delays = reg_req.wr && (reg_req.addr == ADDR_DELAYS);
  wire wr_mask = reg_req.wr && (reg_req.addr == ADDR_FLAG_MASK_A);
  wire [1:0] on_code = delays[ON_DELAY_LSB +: 2];
  wire [1:0] off_code = delays[OFF_DELAY_LSB +: 2];
  wire count_done = (count == '0);
  wire shutdown_now = fault_shutdown && (fault_id != NO_FAULT) && (state != ST_OFF);

  // Delay counts are loaded at the request edge, so later writes wait for the next edge.
  always_comb
  begin
    next_state = state;
    next_count = (count_done) ? count : count - 1'b1;
    case (state)
      ST_OFF:
        if (req_rise)
        begin
          next_state = ST_ON_WAIT;
          next_count = delay_cycles(on_code);
        end
      ST_ON_WAIT:
        if (!power_on_request)
          next_state = ST_OFF;
        else if (count_done)
          next_state = ST_SOFT_START;
      ST_SOFT_START:
        if (req_fall)
        begin
          next_state = ST_OFF_WAIT;
          next_count = delay_cycles(off_code);
        end
        else if (soft_start_done)
          next_state = ST_RUN;
      ST_RUN:
        if (req_fall)
        begin
          next_state = ST_OFF_WAIT;
          next_count = delay_cycles(off_code);
        end
      ST_OFF_WAIT:
        if (count_done)
          next_state = ST_OFF;
      default:
        next_state = ST_OFF;
    endcase
    if (shutdown_now)
      next_state = ST_OFF;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state <= ST_OFF;
      count <= '0;
      req_d <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= next_count;
      req_d <= power_on_request;
    end
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      delays <= DELAYS_RESET;
      flag_mask <= FLAG_MASK_RESET;
    end
    else
    begin
      if (wr_delays)
        delays <= reg_req.wdata[3:0];
      if (wr_mask)
        flag_mask <= reg_req.wdata;
    end
  end

  // The record only changes on a shutdown; software writes to it are ignored.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cur_id <= NO_FAULT;
      prev_id <= NO_FAULT;
    end
    else if (shutdown_now)
    begin
      prev_id <= cur_id;
      cur_id <= fault_id;
    end
  end

  // Only the first identifier since reset is saved, to limit nonvolatile wear.
  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      nvm_save <= 1'b0;
      nvm_save_id <= NO_FAULT;
      first_saved <= 1'b0;
    end
    else
    begin
      nvm_save <= shutdown_now && save_id_enable && !first_saved;
      if (shutdown_now && save_id_enable && !first_saved)
      begin
        nvm_save_id <= fault_id;
        first_saved <= 1'b1;
      end
    end
  end

  assign soft_start = (state == ST_SOFT_START);
  assign converter_on = (state == ST_SOFT_START) || (state == ST_RUN) || (state == ST_OFF_WAIT);
  assign active_flags = soft_start ? (protect_flags & ~flag_mask) : protect_flags;

  always_comb
  begin
    if (reg_req.addr == ADDR_DELAYS)
      reg_rdata = {4'h0, delays};
    else if (reg_req.addr == ADDR_FAULT_RECORD)
      reg_rdata = {prev_id, cur_id};
    else if (reg_req.addr == ADDR_FLAG_MASK_A)
      reg_rdata = flag_mask;
    else
      reg_rdata = 8'h00;
  end

  on_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state == ST_OFF && req_rise && on_code == 2'b00 && !shutdown_now)
      |=> ##1 (state == ST_SOFT_START || !power_on_request || fault_shutdown))
    else $error("Zero turn-on delay did not start soft start.");
  off_zero_a: assert property (@(posedge mclk) disable iff (!reset_n)
    (state == ST_RUN && req_fall && off_code == 2'b00) |=> ##1 !converter_on)
    else $error("Zero turn-off delay did not turn off.");
  record_cur_a: assert property (@(posedge mclk) disable iff (!reset_n)
    shutdown_now |=> reg_rdata[3:0] == $past(fault_id) || reg_req.addr != ADDR_FAULT_RECORD)
    else $error("Shutdown fault not recorded.");
  record_prev_a: assert property (@(posedge mclk) disable iff (!reset_n)
    shutdown_now |=> prev_id == $past(cur_id))
    else $error("Previous fault not shifted.");
  record_shift_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !shutdown_now |=> $stable(cur_id) && $stable(prev_id))
    else $error("Fault record changed without shutdown.");
  mask_soft_a: assert property (@(posedge mclk) disable iff (!reset_n)
    soft_start |-> (active_flags & flag_mask) == 8'h00)
    else $error("Masked flag active in soft start.");
  mask_run_a: assert property (@(posedge mclk) disable iff (!reset_n)
    !soft_start |-> active_flags == protect_flags)
    else $error("Flag masked outside soft start.");
  nvm_once_a: assert property (@(posedge mclk) disable iff (!reset_n)
    nvm_save |=> !nvm_save [*2])
    else $error("Nonvolatile save repeated.");
  reserved_a: assert property (@(posedge mclk) disable iff (!reset_n)
    reg_req.addr == ADDR_DELAYS |-> reg_rdata[7:4] == 4'h0)
    else $error("Reserved delay bits not zero.");

endmodule

// ### tb/psq_host_model.sv
// Host controller model that drives the power-on request and ends soft start.
`timescale 1ns/10ps
module psq_host_model
(
  // Clock.
  input wire logic mclk,
  // Bench commands.
  input wire logic want_on,
  input wire logic ss_ack,
  // Converter side.
  input wire logic soft_start,
  output logic power_on_request,
  output logic soft_start_done
);
  initial
  begin
    power_on_request = 1'b0;
    soft_start_done = 1'b0;
  end
  // Outputs move on the falling edge so the sequencer never samples them mid-change.
  always @(negedge mclk)
  begin
    power_on_request <= want_on;
    soft_start_done <= ss_ack & soft_start;
  end
endmodule

// ### tb/tb_top.sv
// Testbench for the power sequencer and its fault record.
`timescale 1ns/10ps
module tb_top;
  import psq_pkg::*;
  localparam int MSC = 10;
  logic mclk, reset_n, want_on, ss_ack, power_on_request, soft_start_done;
  logic soft_start, converter_on, fault_shutdown, save_id_enable, nvm_save;
  logic [3:0] fault_id, nvm_save_id;
  logic [7:0] reg_rdata, protect_flags, active_flags;
  psq_req_t reg_req;
  int n_mismatch, tests_run, cyc;
  int dly[4] = '{0, DELAY1_MS, DELAY2_MS, DELAY3_MS};
  psq_sequencer #(.MS_CYCLES(MSC)) psq_sequencer_i (.mclk, .reset_n, .reg_req, .reg_rdata,
    .power_on_request, .soft_start_done, .soft_start, .converter_on, .protect_flags,
    .active_flags, .fault_shutdown, .fault_id, .save_id_enable, .nvm_save, .nvm_save_id);
  psq_host_model psq_host_model_i (.mclk, .want_on, .ss_ack, .soft_start,
    .power_on_request, .soft_start_done);
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // The longest delay code dominates the run, so the ceiling sits well above it.
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      results();
    end
  end
  task automatic results();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    tests_run = tests_run + 1;
    if (got !== exp)
    begin
      n_mismatch = n_mismatch + 1;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_req = {1'b1, 1'b0, a, d};
    @(negedge mclk);
    reg_req.wr = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    reg_req.addr = a;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic set_on(input logic v);
    @(negedge mclk);
    #1;
    want_on = v;
    @(negedge mclk);
    #1;
  endtask
  // Checks that the edge neither comes before the count runs out nor much after.
  task automatic edge_wait(input int n, input logic up);
    repeat (n) @(negedge mclk);
    chk("early", 8'h00, {7'h0, up ? soft_start : !converter_on});
    for (int k = 0; k < 4 && !(up ? soft_start : !converter_on); k++)
      @(negedge mclk);
    chk("late", 8'h01, {7'h0, up ? soft_start : !converter_on});
  endtask
  initial
  begin
    reset_n = 1'b0;
    want_on = 1'b0;
    ss_ack = 1'b1;
    fault_shutdown = 1'b0;
    fault_id = 4'h0;
    save_id_enable = 1'b1;
    protect_flags = 8'hff;
    reg_req = '0;
    n_mismatch = 0;
    tests_run = 0;
    cyc = 0;
    repeat (4) @(negedge mclk);
    reset_n = 1'b1;
    rd(ADDR_DELAYS, 8'h00);
    rd(ADDR_FAULT_RECORD, 8'h00);
    rd(ADDR_FLAG_MASK_A, FLAG_MASK_RESET);
    rd(16'hfe0a, 8'h00);
    wr(ADDR_DELAYS, 8'hff);
    rd(ADDR_DELAYS, 8'h0f);
    wr(ADDR_FAULT_RECORD, 8'h5a);
    rd(ADDR_FAULT_RECORD, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      wr(ADDR_DELAYS, 8'(c * 5));
      set_on(1'b1);
      edge_wait(dly[c] * MSC, 1'b1);
      set_on(1'b0);
      edge_wait(dly[c] * MSC, 1'b0);
    end
    ss_ack = 1'b0;
    wr(ADDR_DELAYS, 8'h00);
    set_on(1'b1);
    edge_wait(0, 1'b1);
    for (int i = 0; i < 8; i++)
    begin
      wr(ADDR_FLAG_MASK_A, 8'h01 << i);
      chk("active_flags", ~(8'h01 << i), active_flags);
    end
    ss_ack = 1'b1;
    repeat (3) @(negedge mclk);
    chk("active_flags", 8'hff, active_flags);
    for (int f = 1; f < 12; f++)
    begin
      @(negedge mclk);
      fault_shutdown = 1'b1;
      fault_id = 4'(f);
      @(negedge mclk);
      fault_shutdown = 1'b0;
      chk("nvm_save", {7'h0, f == 1}, {7'h0, nvm_save});
      if (f == 1)
        chk("nvm_save_id", 8'h01, {4'h0, nvm_save_id});
      chk("converter_on", 8'h00, {7'h0, converter_on});
      rd(ADDR_FAULT_RECORD, {4'(f - 1), 4'(f)});
      set_on(1'b0);
      set_on(1'b1);
      edge_wait(0, 1'b1);
    end
    // A mid-run reset clears the record, and with saving disabled no save pulse may follow.
    save_id_enable = 1'b0;
    set_on(1'b0);
    repeat (4) @(negedge mclk);
    reset_n = 1'b0;
    @(negedge mclk);
    reset_n = 1'b1;
    rd(ADDR_FAULT_RECORD, 8'h00);
    set_on(1'b1);
    edge_wait(0, 1'b1);
    @(negedge mclk);
    fault_shutdown = 1'b1;
    fault_id = 4'h3;
    @(negedge mclk);
    fault_shutdown = 1'b0;
    chk("nvm_save", 8'h00, {7'h0, nvm_save});
    rd(ADDR_FAULT_RECORD, 8'h03);
    results();
  end
endmodule
